// [verilog/rx_clk_sel_pkg.sv]
// constants and carrier types for the receive fifo clock selection block
package rx_clk_sel_pkg;
    // register byte offsets
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] STATUS_OFS = 8'h04;
    localparam logic [7:0] PLL_CFG_OFS = 8'h08;
    localparam logic [7:0] FOUT_OFS = 8'h0c;
    // control fields
    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_BYTE_SER = 3;
    localparam int CTRL_USER_RD = 4;
    localparam int CTRL_REUSE = 5;
    localparam int CTRL_PFD_PD = 6;
    localparam int CTRL_BOND_REQ = 7;
    localparam int CTRL_BW_LSB = 8;
    localparam int CTRL_MULT_RX_LSB = 10;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    localparam logic [31:0] CTRL_MASK = 32'h0000_0fff;
    // status fields
    localparam int STAT_LOCK = 0;
    localparam int STAT_MISMATCH = 1;
    localparam int STAT_REFUSED = 2;
    localparam int STAT_BUSY = 3;
    // pll reuse config fields: rate in Mbps low half, width high half
    localparam int CFG_RATE_LSB = 0;
    localparam int CFG_WIDTH_LSB = 16;
    localparam logic [31:0] PLL_CFG_RESET = 32'h0000_0000;
    // channel configuration codes
    localparam logic [2:0] MODE_NB_RM = 3'h0;
    localparam logic [2:0] MODE_NB_NORM = 3'h1;
    localparam logic [2:0] MODE_X4 = 3'h2;
    localparam logic [2:0] MODE_X8 = 3'h3;
    localparam logic [2:0] MODE_PMA_DIRECT = 3'h4;
    // channels per transceiver block
    localparam int NUM_REG_CH = 4;
    localparam int NUM_MULT_CH = 2;
    localparam int CH_TOTAL = NUM_REG_CH + NUM_MULT_CH;
    // clock rate comparison window
    localparam longint CLK_HZ = 20_000_000;
    localparam longint CMP_WINDOW_US = 50;
    localparam int CMP_WINDOW_CYCLES = int'(CLK_HZ * CMP_WINDOW_US / 1_000_000);
    localparam int CMP_TOL = 1;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        WR_TX_PARALLEL, WR_RECOVERED, WR_CORE_LOCAL, WR_CORE_MASTER
    } wr_src_e;
    typedef enum logic {RD_DEFAULT, RD_USER} rd_src_e;

    typedef struct packed {
        logic awvalid;
        logic [7:0] awaddr;
        logic wvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bready;
        logic arvalid;
        logic [7:0] araddr;
        logic rready;
    } axil_req_s;

    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } axil_rsp_s;

    typedef struct packed {
        wr_src_e wr_src;
        logic wr_halve;
        rd_src_e rd_src;
        logic bond_en;
        logic [CH_TOTAL-1:0] rx_own_clk;
        logic [NUM_MULT_CH-1:0] mult_pma_only;
        logic tx_from_aux_pll;
        logic fab_pll_en;
        logic fab_pll_pfd_pd;
        logic [1:0] fab_pll_bw;
    } clk_sel_s;
endpackage

// [verilog/rx_clk_sel.sv]
// receive fifo clock selection, pll reuse and rate check with axi4-lite registers
//
// Overview of operation
// [R1] Non-bonded, rate matcher: write clock is local tx parallel clock, halved by serializer.
// [R2] Non-bonded, no rate matcher: write clock is channel recovered clock, halved by serializer.
// [R3] Four-lane: write clock is own block first_multiplier_channel clock, halved by serializer.
// [R4] Eight-lane: write clock is master block first_multiplier_channel clock, halved likewise.
// [R5] The shared read clock driver must be 0 ppm to every write clock it serves.
// [R6] The read clock input may only come from the listed dedicated clock sources.
// [R7] Gated clocks and fabric-made clocks must never drive the fifo clock inputs.
// [R8] In PMA-direct mode every receiver channel is clocked by its own recovered clock.
// [R9] PMA-direct receivers never bond.
// [R10] A reused idle pll gives one output, settable bandwidth, pfd power-down and lock status.
// [R11] The reused pll output frequency equals data rate divided by channel width.
// [R12] A block has four regular and two multiplier channels, all PMA-direct multi-lane capable.
// [R13] A PMA-only multiplier_channel takes serial data on its refclk pins and its pll is a cdr.
// [R14] With all multiplier plls receiving, the auxiliary_transmit_pll makes all tx clocks.
// [R15] At 6.5 Gbps fabric tx logic runs on tx parallel clock shifted 315 degrees.
// [R16] With the user read clock enabled, it clocks the fifo read side instead of the default.
// [R17] Any read to write clock frequency difference corrupts fifo data; flagged only with the user read clock and an edge count gap over CMP_TOL.
`timescale 1ns/1ps
`default_nettype none
module rx_clk_sel
    import rx_clk_sel_pkg::*;
#(
    parameter int WINDOW_CYCLES = CMP_WINDOW_CYCLES
)(
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // register bus
    input wire axil_req_s bus_req,
    output axil_rsp_s bus_rsp,
    // monitored pins: pll lock, write clock, read clock
    input wire logic pll_lock_pin,
    input wire logic wr_clk_mon,
    input wire logic rd_clk_mon,
    // clock selection to the channels
    output clk_sel_s sel
);
    // window counter is 16 bits wide
    if (WINDOW_CYCLES < 2 || WINDOW_CYCLES > 65535)
    begin : gen_window_check
        $error("WINDOW_CYCLES out of range");
    end

    typedef struct packed {
        axil_rsp_s rsp;
        logic aw_have;
        logic [7:0] aw_addr;
        logic w_have;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic [31:0] ctrl;
        logic [31:0] pll_cfg;
        logic mismatch;
        logic refused;
        logic [2:0][2:0] sync;
        logic [2:0] filt;
        logic [15:0] win_cnt;
        logic [15:0] wr_cnt;
        logic [15:0] rd_cnt;
        logic busy;
        logic [4:0] steps;
        logic [16:0] rem;
        logic [15:0] quo;
        logic [15:0] fout;
        clk_sel_s sel;
    } state_s;

    state_s q;
    state_s next_q;

    wire logic [2:0] mode = q.ctrl[CTRL_MODE_LSB +: 3];
    wire logic [7:0] width = q.pll_cfg[CFG_WIDTH_LSB +: 8];

    always_comb
    begin
        logic [31:0] wval;
        logic [31:0] cur;
        logic [16:0] trial;
        logic [15:0] diff;
        logic wmapped;
        logic mis_set;
        wval = '0;
        cur = '0;
        trial = '0;
        diff = '0;
        wmapped = 1'b0;
        mis_set = 1'b0;
        next_q = q;

        // pin inputs through three stages, change taken when 2nd and 3rd agree
        next_q.sync[0] = {q.sync[0][1:0], pll_lock_pin};
        next_q.sync[1] = {q.sync[1][1:0], wr_clk_mon};
        next_q.sync[2] = {q.sync[2][1:0], rd_clk_mon};
        for (int i = 0; i < 3; i++)
        begin
            if (q.sync[i][1] == q.sync[i][2])
                next_q.filt[i] = q.sync[i][2];
        end

        // rate comparison over a fixed window
        if (next_q.filt[1] && !q.filt[1])
            next_q.wr_cnt = q.wr_cnt + 16'h0001;
        if (next_q.filt[2] && !q.filt[2])
            next_q.rd_cnt = q.rd_cnt + 16'h0001;
        if (q.win_cnt == 16'(WINDOW_CYCLES - 1))
        begin
            diff = (q.wr_cnt > q.rd_cnt) ? q.wr_cnt - q.rd_cnt : q.rd_cnt - q.wr_cnt;
            if (q.sel.rd_src == RD_USER && diff > 16'(CMP_TOL))
            begin
                next_q.mismatch = 1'b1; // R17
                mis_set = 1'b1;
            end
            next_q.win_cnt = '0;
            next_q.wr_cnt = '0;
            next_q.rd_cnt = '0;
        end
        else
        begin
            next_q.win_cnt = q.win_cnt + 16'h0001;
        end

        // output frequency = rate / width by restoring division
        if (q.busy)
        begin
            trial = {q.rem[15:0], q.quo[15]};
            if (trial >= {9'h000, width})
            begin
                next_q.rem = trial - {9'h000, width};
                next_q.quo = {q.quo[14:0], 1'b1};
            end
            else
            begin
                next_q.rem = trial;
                next_q.quo = {q.quo[14:0], 1'b0};
            end
            next_q.steps = q.steps - 5'h01;
            if (q.steps == 5'h01)
            begin
                next_q.busy = 1'b0;
                next_q.fout = next_q.quo; // R11
            end
        end

        // write channel: address and data taken in either order
        if (bus_req.awvalid && q.rsp.awready)
        begin
            next_q.aw_have = 1'b1;
            next_q.aw_addr = bus_req.awaddr;
            next_q.rsp.awready = 1'b0;
        end
        if (bus_req.wvalid && q.rsp.wready)
        begin
            next_q.w_have = 1'b1;
            next_q.w_data = bus_req.wdata;
            next_q.w_strb = bus_req.wstrb;
            next_q.rsp.wready = 1'b0;
        end
        if (q.aw_have && q.w_have)
        begin
            case (q.aw_addr)
                CTRL_OFS: cur = q.ctrl;
                STATUS_OFS: cur = '0;
                PLL_CFG_OFS: cur = q.pll_cfg;
                default: cur = '0;
            endcase
            for (int b = 0; b < 4; b++)
                wval[8*b +: 8] = q.w_strb[b] ? q.w_data[8*b +: 8] : cur[8*b +: 8];
            wmapped = 1'b1;
            case (q.aw_addr)
                CTRL_OFS:
                begin
                    next_q.ctrl = wval & CTRL_MASK;
                    if (wval[CTRL_MODE_LSB +: 3] == MODE_PMA_DIRECT && wval[CTRL_BOND_REQ])
                        next_q.refused = 1'b1; // R9
                end
                STATUS_OFS:
                begin
                    // a set in the same cycle wins over the clear
                    if (wval[STAT_MISMATCH] && !mis_set)
                        next_q.mismatch = 1'b0;
                    if (wval[STAT_REFUSED])
                        next_q.refused = 1'b0;
                end
                PLL_CFG_OFS:
                begin
                    next_q.pll_cfg = wval;
                    next_q.busy = 1'b1;
                    next_q.steps = 5'h10;
                    next_q.rem = '0;
                    next_q.quo = wval[CFG_RATE_LSB +: 16];
                    if (wval[CFG_WIDTH_LSB +: 8] == 8'h00)
                    begin
                        next_q.busy = 1'b0;
                        next_q.fout = '0;
                    end
                end
                default: wmapped = 1'b0;
            endcase
            next_q.aw_have = 1'b0;
            next_q.w_have = 1'b0;
            next_q.rsp.bvalid = 1'b1;
            next_q.rsp.bresp = wmapped ? RESP_OKAY : RESP_SLVERR;
        end
        if (q.rsp.bvalid && bus_req.bready)
        begin
            next_q.rsp.bvalid = 1'b0;
            next_q.rsp.awready = 1'b1;
            next_q.rsp.wready = 1'b1;
        end

        // read channel
        if (bus_req.arvalid && q.rsp.arready)
        begin
            next_q.rsp.arready = 1'b0;
            next_q.rsp.rvalid = 1'b1;
            next_q.rsp.rresp = RESP_OKAY;
            case (bus_req.araddr)
                CTRL_OFS: next_q.rsp.rdata = q.ctrl;
                STATUS_OFS: next_q.rsp.rdata = {28'h0000000, q.busy, q.refused, q.mismatch,
                    q.filt[0]}; // R10
                PLL_CFG_OFS: next_q.rsp.rdata = q.pll_cfg;
                FOUT_OFS: next_q.rsp.rdata = {16'h0000, q.fout};
                default:
                begin
                    next_q.rsp.rdata = '0;
                    next_q.rsp.rresp = RESP_SLVERR;
                end
            endcase
        end
        if (q.rsp.rvalid && bus_req.rready)
        begin
            next_q.rsp.rvalid = 1'b0;
            next_q.rsp.arready = 1'b1;
        end

        // clock selection from the configuration
        case (mode)
            MODE_NB_RM: next_q.sel.wr_src = WR_TX_PARALLEL; // R1
            MODE_X4: next_q.sel.wr_src = WR_CORE_LOCAL; // R3
            MODE_X8: next_q.sel.wr_src = WR_CORE_MASTER; // R4
            default: next_q.sel.wr_src = WR_RECOVERED; // R2 R8
        endcase
        next_q.sel.wr_halve = q.ctrl[CTRL_BYTE_SER] && mode != MODE_PMA_DIRECT;
        next_q.sel.rd_src = q.ctrl[CTRL_USER_RD] ? RD_USER : RD_DEFAULT; // R16
        next_q.sel.bond_en = mode == MODE_X4 || mode == MODE_X8; // R9
        for (int c = 0; c < CH_TOTAL; c++)
        begin
            if (c < NUM_REG_CH)
                next_q.sel.rx_own_clk[c] = mode == MODE_PMA_DIRECT; // R8 R12
            else
                next_q.sel.rx_own_clk[c] = mode == MODE_PMA_DIRECT
                    && q.ctrl[CTRL_MULT_RX_LSB + c - NUM_REG_CH]; // R12
        end
        next_q.sel.mult_pma_only = (mode == MODE_PMA_DIRECT)
            ? q.ctrl[CTRL_MULT_RX_LSB +: NUM_MULT_CH] : '0; // R13
        next_q.sel.tx_from_aux_pll = mode == MODE_PMA_DIRECT
            && (&q.ctrl[CTRL_MULT_RX_LSB +: NUM_MULT_CH]); // R14
        next_q.sel.fab_pll_en = q.ctrl[CTRL_REUSE]; // R10
        next_q.sel.fab_pll_pfd_pd = q.ctrl[CTRL_REUSE] && q.ctrl[CTRL_PFD_PD];
        next_q.sel.fab_pll_bw = q.ctrl[CTRL_BW_LSB +: 2];
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            q <= '0;
            q.rsp.awready <= 1'b1;
            q.rsp.wready <= 1'b1;
            q.rsp.arready <= 1'b1;
        end
        else
        begin
            q <= next_q;
        end
    end

    assign bus_rsp = q.rsp;
    assign sel = q.sel;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    AST_WR_RM: assert property (mode == MODE_NB_RM |=> sel.wr_src == WR_TX_PARALLEL // R1
        && sel.wr_halve == $past(q.ctrl[CTRL_BYTE_SER])) else $error("rm write clock wrong");
    AST_WR_NORM: assert property (mode == MODE_NB_NORM ##1 mode == MODE_NB_NORM // R2
        |-> sel.wr_src == WR_RECOVERED) else $error("recovered write clock wrong");
    AST_WR_X4: assert property (mode == MODE_X4 // R3
        |=> sel.wr_src == WR_CORE_LOCAL && sel.bond_en) else $error("x4 write clock wrong");
    AST_WR_X8: assert property (mode == MODE_X8 |=> sel.wr_src == WR_CORE_MASTER // R4
        && sel.wr_halve == $past(q.ctrl[CTRL_BYTE_SER])) else $error("x8 write clock wrong");
    AST_PMA_OWN: assert property (mode == MODE_PMA_DIRECT // R8
        |=> &sel.rx_own_clk[NUM_REG_CH-1:0]) else $error("pma channel not on own clock");
    AST_PMA_NOBOND: assert property (mode == MODE_PMA_DIRECT // R9
        |=> !sel.bond_en && !sel.wr_halve) else $error("pma direct bonded");
    AST_FOUT: assert property ($fell(q.busy) |-> width == 8'h00 // R11
        || q.fout == q.pll_cfg[15:0] / {8'h00, width}) else $error("fout not rate over width");
    AST_AUX_PLL: assert property (sel.tx_from_aux_pll |-> &sel.mult_pma_only) // R14
        else $error("aux pll used while multiplier free");
    AST_USER_RD: assert property ($rose(q.ctrl[CTRL_USER_RD]) |=> sel.rd_src == RD_USER) // R16
        else $error("user read clock not selected");
    AST_MISMATCH: assert property (q.win_cnt == 16'(WINDOW_CYCLES - 1) // R17
        && sel.rd_src == RD_USER && q.wr_cnt > q.rd_cnt + 16'h0002 |=> q.mismatch)
        else $error("mismatch missed");
    AST_PFD: assert property (sel.fab_pll_pfd_pd |-> sel.fab_pll_en) // R10
        else $error("pfd power-down without reuse");
endmodule // rx_clk_sel
`default_nettype wire

// [verification/fabric_clk_model.sv]
// fabric side model: monitored fifo clocks and reused pll lock
`timescale 1ns/1ps
`default_nettype none
module fabric_clk_model (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // control from bench
    input wire logic [3:0] rd_half,
    input wire logic lock_in,
    // monitored pins
    output logic wr_clk_mon,
    output logic rd_clk_mon,
    output logic pll_lock_pin,
    // fabric tx data clock, write clock one eighth early: 315 degrees late
    output logic tx_shift_clk
);
    logic [3:0] wc;
    logic [3:0] rc;

    // read clock from a dedicated ungated source; half period 4 is 0 ppm
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            wc <= 4'h0;
            rc <= 4'h0;
            wr_clk_mon <= 1'b0;
            rd_clk_mon <= 1'b0;
            pll_lock_pin <= 1'b0;
            tx_shift_clk <= 1'b0;
        end
        else
        begin
            wc <= (wc == 4'h3) ? 4'h0 : wc + 4'h1;
            wr_clk_mon <= (wc == 4'h3) ? !wr_clk_mon : wr_clk_mon;
            rc <= (rc >= rd_half - 4'h1) ? 4'h0 : rc + 4'h1;
            rd_clk_mon <= (rc >= rd_half - 4'h1) ? !rd_clk_mon : rd_clk_mon;
            pll_lock_pin <= lock_in;
            tx_shift_clk <= (wc == 4'h2) ? !tx_shift_clk : tx_shift_clk;
        end
    end
endmodule // fabric_clk_model
`default_nettype wire

// [verification/rx_clk_sel_tb.sv]
// self-checking bench for the receive fifo clock selection block
`timescale 1ns/1ps
`default_nettype none
module rx_clk_sel_tb
    import rx_clk_sel_pkg::*;
;
    localparam int WIN = 100;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    axil_req_s req = '0;
    axil_rsp_s rsp;
    clk_sel_s sel;
    logic [3:0] rd_half = 4'h4;
    logic lock_in = 1'b0;
    logic wr_mon;
    logic rd_mon;
    logic lock_pin;
    logic tx_shift;
    int failures = 0;
    int samples_checked = 0;
    logic [31:0] rd;
    logic [1:0] rs;

    always #25 clk = ~clk;

    rx_clk_sel #(.WINDOW_CYCLES(WIN)) rx_clk_sel_i (
        .clk(clk), .rst_n(rst_n), .bus_req(req), .bus_rsp(rsp),
        .pll_lock_pin(lock_pin), .wr_clk_mon(wr_mon), .rd_clk_mon(rd_mon), .sel(sel));
    fabric_clk_model fabric_clk_model_i (
        .clk(clk), .rst_n(rst_n), .rd_half(rd_half), .lock_in(lock_in),
        .wr_clk_mon(wr_mon), .rd_clk_mon(rd_mon), .pll_lock_pin(lock_pin),
        .tx_shift_clk(tx_shift));

    task automatic close_out();
        $display("checks %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            failures++;
            $display("mismatch t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic hang(input int n);
        if (n >= 64)
        begin
            failures++;
            $display("mismatch t=%0t bus wait ran out", $time);
            close_out();
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask

    // one write; address and data released each when taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        int n;
        logic pa;
        logic pw;
        n = 0;
        pa = 1'b1;
        pw = 1'b1;
        req.awvalid <= 1'b1;
        req.awaddr <= a;
        req.wvalid <= 1'b1;
        req.wdata <= d;
        req.wstrb <= 4'hf;
        req.bready <= 1'b1;
        while ((pa || pw) && n < 64)
        begin
            @(posedge clk);
            n++;
            if (pa && rsp.awready)
                req.awvalid <= 1'b0;
            if (pw && rsp.wready)
                req.wvalid <= 1'b0;
            pa = pa && !rsp.awready;
            pw = pw && !rsp.wready;
        end
        hang(n);
        n = 0;
        do
            @(posedge clk);
        while (!rsp.bvalid && ++n < 64);
        hang(n);
        rs = rsp.bresp;
        req.bready <= 1'b0;
    endtask

    task automatic rdr(input logic [7:0] a);
        int n;
        n = 0;
        req.arvalid <= 1'b1;
        req.araddr <= a;
        req.rready <= 1'b1;
        do
            @(posedge clk);
        while (!rsp.arready && ++n < 64);
        hang(n);
        req.arvalid <= 1'b0;
        n = 0;
        do
            @(posedge clk);
        while (!rsp.rvalid && ++n < 64);
        hang(n);
        rd = rsp.rdata;
        rs = rsp.rresp;
        req.rready <= 1'b0;
        @(posedge clk);
    endtask

    task automatic rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        rdr(a);
        chk(rd & m, e);
    endtask

    task automatic t_modes();
        wr_src_e tab [4] = '{WR_TX_PARALLEL, WR_RECOVERED, WR_CORE_LOCAL, WR_CORE_MASTER};
        chk(32'(sel), 32'h0);
        rchk(CTRL_OFS, 32'hffff_ffff, CTRL_RESET);
        for (int m = 0; m < 4; m++)
        begin
            for (int b = 0; b < 2; b++)
            begin
                wr(CTRL_OFS, 32'(m) | (32'(b) << CTRL_BYTE_SER));
                cyc(2);
                chk(32'(sel.wr_src), 32'(tab[m]));
                chk(32'(sel.wr_halve), 32'(b));
            end
        end
        rchk(CTRL_OFS, 32'hffff_ffff, 32'h0000_000b);
    endtask

    task automatic t_pma();
        wr(CTRL_OFS, 32'h0000_0c8c);
        cyc(2);
        chk(32'(sel.wr_src), 32'(WR_RECOVERED));
        chk(32'(sel.rx_own_clk), 32'h3f);
        chk(32'({sel.wr_halve, sel.bond_en}), 32'h0);
        chk(32'({sel.mult_pma_only, sel.tx_from_aux_pll}), 32'h7);
        rchk(STATUS_OFS, 32'h4, 32'h4);
        wr(STATUS_OFS, 32'h4);
        rchk(STATUS_OFS, 32'h4, 32'h0);
    endtask

    task automatic t_rate();
        logic p;
        wr(CTRL_OFS, 32'h10);
        cyc(2);
        chk(32'(sel.rd_src), 32'(RD_USER));
        // tx data clock leads the write clock by one cycle of eight
        repeat (8)
        begin
            p = tx_shift;
            @(posedge clk);
            chk(32'(wr_mon), 32'(p));
        end
        wr(STATUS_OFS, 32'h6);
        cyc(3 * WIN);
        rchk(STATUS_OFS, 32'h2, 32'h0);
        rd_half <= 4'h8;
        cyc(3 * WIN);
        rchk(STATUS_OFS, 32'h2, 32'h2);
        rd_half <= 4'h4;
        wr(CTRL_OFS, 32'h0);
        cyc(2);
        chk(32'(sel.rd_src), 32'(RD_DEFAULT));
    endtask

    task automatic t_pll();
        lock_in <= 1'b1;
        wr(CTRL_OFS, 32'h0000_0260);
        cyc(2);
        chk(32'({sel.fab_pll_en, sel.fab_pll_pfd_pd, sel.fab_pll_bw}), 32'he);
        rchk(STATUS_OFS, 32'h1, 32'h1);
        wr(PLL_CFG_OFS, 32'h000a_09c4);
        rchk(STATUS_OFS, 32'h8, 32'h8);
        cyc(16);
        rchk(FOUT_OFS, 32'hffff_ffff, 32'h0000_00fa);
        wr(PLL_CFG_OFS, 32'h0);
        rchk(FOUT_OFS, 32'hffff_ffff, 32'h0);
        lock_in <= 1'b0;
        cyc(6);
        rchk(STATUS_OFS, 32'h1, 32'h0);
        // unmapped place refused, control word untouched
        wr(8'h10, 32'hffff_ffff);
        chk(32'(rs), 32'(RESP_SLVERR));
        rchk(8'h10, 32'hffff_ffff, 32'h0);
        chk(32'(rs), 32'(RESP_SLVERR));
        rchk(CTRL_OFS, 32'hffff_ffff, 32'h0000_0260);
    endtask

    initial
    begin
        cyc(16);
        rst_n <= 1'b1;
        cyc(1);
        t_modes();
        t_pma();
        t_rate();
        t_pll();
        close_out();
    end
endmodule // rx_clk_sel_tb
`default_nettype wire
